// ### csw_cfg.svh
// Function
// - Every transfer is eight serial-clocked bits
// - Duplex mode: buffer write starts transfer
// - Receive-only mode: shift register read starts
// - Gated slave: select low lets start
// - Gated slave: select high holds off starts
// - Held request starts once select falls
// - Select rising mid-transfer suspends it
// - Started transfer raises in-progress flag
// - Eighth bit: done flag, busy clears
// - Disabled or unused pins stay ports
// - Disable clears busy flag and shifter
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH

// -------------------------------------------------------------
// Word and clock constants
// -------------------------------------------------------------
`define CSW_BITS 8
`define CSW_SLAVE_SRC 3'h7
`define CSW_HALF_BASE 2
`define CSW_DIV_W 8
`define CSW_RESET_BYTE 8'h00

`endif

// ### csw_pkg.sv
package csw_pkg;
    // -------------------------------------------------------------
    // Types
    // -------------------------------------------------------------
    // Transfer states, Gray coded along idle-pend-run-suspend
    typedef enum logic [1:0] {
        CSW_IDLE = 2'h0,
        CSW_PEND = 2'h1,
        CSW_RUN = 2'h3,
        CSW_SUSP = 2'h2
    } csw_state_t;
    // Clock source selection code
    typedef logic [2:0] csw_sel_t;
endpackage

// ### csw_clk_if.sv
`timescale 1ns/100ps
`default_nettype none
// -------------------------------------------------------------
// Serial clock carrier between control and clock generator
// -------------------------------------------------------------
interface csw_clk_if;
    logic master; // Device drives the serial clock
    logic run; // Transfer is active
    logic ckp; // Clock polarity
    logic [2:0] sel; // Clock source selection
    logic pin_i; // Raw serial clock pin level
    logic lead; // Leading edge pulse
    logic trail; // Trailing edge pulse
    logic sck_o; // Driven serial clock level
    modport ctl (output master, run, ckp, sel, pin_i,
                 input lead, trail, sck_o);
    modport gen (input master, run, ckp, sel, pin_i,
                 output lead, trail, sck_o);
endinterface
`default_nettype wire

// ### csw_sck_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "csw_cfg.svh"
module csw_sck_gen #(
    parameter int DIV_W = `CSW_DIV_W
) (
    input wire logic clk,
    input wire logic rst_b,
    csw_clk_if.gen cif
);
    import csw_pkg::*;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    // The slowest master rate needs a half period of 128 cycles
    if (DIV_W < 8) begin : g_bad_div
        $error("csw_sck_gen: DIV_W too small for slowest rate");
    end

    logic [DIV_W-1:0] div_q; // Half period counter
    logic [DIV_W-1:0] limit; // Last count of a half period
    logic tick; // Half period elapsed
    logic gen_on; // Master clock is running
    logic sck_o_q; // Driven clock level
    logic s1_q; // First sync stage
    logic s2_q; // Second sync stage
    logic s3_q; // Previous synced level
    logic lead_q; // Leading edge pulse
    logic trail_q; // Trailing edge pulse

    // Half period is 2, 4, ... 128 cycles by selection code
    assign limit = DIV_W'((`CSW_HALF_BASE << cif.sel) - 1);
    assign gen_on = cif.master & cif.run;
    assign tick = gen_on & (div_q == limit);

    // -------------------------------------------------------------
    // Master divider
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
        end else if (!gen_on || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Idle level follows polarity so the pin rests at type level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_o_q <= 1'b1;
        end else if (!gen_on) begin
            sck_o_q <= ~cif.ckp;
        end else if (tick) begin
            sck_o_q <= ~sck_o_q;
        end
    end

    // -------------------------------------------------------------
    // External clock sampling
    // -------------------------------------------------------------
    // The pin is asynchronous; only s2 onward is inspected
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= cif.pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Edges are seen on the normalised clock (pin xor polarity),
    // whose idle level is one; its fall is the leading edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lead_q <= 1'b0;
            trail_q <= 1'b0;
        end else if (cif.master) begin
            lead_q <= tick & (sck_o_q ^ cif.ckp);
            trail_q <= tick & ~(sck_o_q ^ cif.ckp);
        end else begin
            lead_q <= (s3_q ^ cif.ckp) & ~(s2_q ^ cif.ckp);
            trail_q <= ~(s3_q ^ cif.ckp) & (s2_q ^ cif.ckp);
        end
    end

    assign cif.sck_o = sck_o_q;
    assign cif.lead = lead_q;
    assign cif.trail = trail_q;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    property p_idle_level;
        @(posedge clk) disable iff (!rst_b)
        (!gen_on ##1 !gen_on) |-> (sck_o_q == ~$past(cif.ckp));
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("master clock not at idle level");
endmodule
`default_nettype wire

// ### csw_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "csw_cfg.svh"
module csw_top #(
    parameter int BITS = `CSW_BITS
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CHANNEL_ENABLE,
    input wire logic DUPLEX_SELECT,
    input wire logic SELECT_GATING_ENABLE,
    input wire logic BIT_ORDER_LSB,
    input wire logic CLOCK_POLARITY,
    input wire logic DATA_PHASE,
    input wire csw_pkg::csw_sel_t CLOCK_SOURCE_SEL,
    input wire logic TX_BUFFER_WR,
    input wire logic [BITS-1:0] TX_BUFFER_DATA,
    input wire logic SHIFT_REG_RD,
    output logic [BITS-1:0] SHIFT_REG_Q,
    output logic XFER_IN_PROGRESS,
    output logic XFER_DONE_IRQ_FLAG,
    input wire logic SERIAL_CLOCK_PIN_I,
    output logic SERIAL_CLOCK_PIN_O,
    output logic SERIAL_CLOCK_PIN_OE,
    output logic SERIAL_OUT_PIN_O,
    output logic SERIAL_OUT_PIN_OE,
    input wire logic SERIAL_IN_PIN_I,
    input wire logic SLAVE_SELECT_IN
);
    import csw_pkg::*;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    // A shift register of fewer than two bits cannot shift
    if (BITS < 2) begin : g_bad_bits
        $error("csw_top: BITS must be at least 2");
    end

    localparam int ECW = $clog2(2 * BITS); // Edge counter width
    localparam logic [ECW-1:0] LAST_EDGE = ECW'(2 * BITS - 1);

    // -------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------
    csw_clk_if cif(); // Link to the clock generator
    csw_state_t state_q; // Transfer state
    logic [BITS-1:0] tx_q; // Transmit buffer contents
    logic [BITS-1:0] sh_q; // Shift register
    logic [ECW-1:0] ecnt_q; // Clock edges seen this word
    logic busy_q; // Transfer in progress
    logic done_q; // Word complete pulse
    logic so_q; // Serial out level
    logic sck_oe_q; // Clock pin driven
    logic so_oe_q; // Serial out pin driven
    logic si1_q; // Serial in first sync stage
    logic si2_q; // Serial in second sync stage
    logic ss1_q; // Select first sync stage
    logic ss2_q; // Select second sync stage
    logic master; // Internal clock source chosen
    logic gate; // Select gating in force
    logic ss_hi; // Gated select is high
    logic start_req; // Software asked for a word
    logic go; // Transfer begins now
    logic run_edge; // Any edge while running
    logic smp; // Sampling edge
    logic outedge; // Output-change edge
    logic last; // Final edge of the word
    logic out_bit; // Bit presented next
    logic [BITS-1:0] sh_in; // Shift register after sampling
    logic off_val; // Serial out level when disabled
    logic [BITS-1:0] load_word; // Word loaded at start

    // -------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------
    // Serial in and select are asynchronous to CLK
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            si1_q <= 1'b0;
            si2_q <= 1'b0;
            ss1_q <= 1'b1;
            ss2_q <= 1'b1;
        end else begin
            si1_q <= SERIAL_IN_PIN_I;
            si2_q <= si1_q;
            ss1_q <= SLAVE_SELECT_IN;
            ss2_q <= ss1_q;
        end
    end

    // -------------------------------------------------------------
    // Mode decode
    // -------------------------------------------------------------
    // Code seven takes the clock from the pin
    assign master = (CLOCK_SOURCE_SEL != `CSW_SLAVE_SRC);
    // Gating only counts in slave mode
    assign gate = SELECT_GATING_ENABLE & ~master;
    assign ss_hi = gate & ss2_q;
    // Duplex starts on a buffer write, receive-only on a read
    assign start_req = CHANNEL_ENABLE &
        (DUPLEX_SELECT ? TX_BUFFER_WR : SHIFT_REG_RD);
    // Start now from idle when select is low, or release a pend
    assign go = CHANNEL_ENABLE & ~ss_hi &
        (((state_q == CSW_IDLE) & start_req) |
         (state_q == CSW_PEND));

    // Edge roles by phase: phase 0 samples on trailing edges
    assign run_edge = (state_q == CSW_RUN) & (cif.lead | cif.trail);
    assign smp = (state_q == CSW_RUN) &
        (DATA_PHASE ? cif.lead : cif.trail);
    assign outedge = (state_q == CSW_RUN) &
        (DATA_PHASE ? cif.trail : cif.lead);
    assign last = run_edge & (ecnt_q == LAST_EDGE);

    // Bit order picks which end leaves and which end fills
    assign out_bit = BIT_ORDER_LSB ? sh_q[0] : sh_q[BITS-1];
    assign sh_in = BIT_ORDER_LSB ? {si2_q, sh_q[BITS-1:1]} :
        {sh_q[BITS-2:0], si2_q};
    // A write in the starting cycle has not reached the buffer yet
    assign load_word = TX_BUFFER_WR ? TX_BUFFER_DATA : tx_q;
    // Stopped level: low unless duplex with phase 1
    assign off_val = DUPLEX_SELECT & DATA_PHASE &
        (BIT_ORDER_LSB ? tx_q[0] : tx_q[BITS-1]);

    // -------------------------------------------------------------
    // Clock generator
    // -------------------------------------------------------------
    assign cif.master = master;
    assign cif.run = (state_q == CSW_RUN);
    assign cif.ckp = CLOCK_POLARITY;
    assign cif.sel = CLOCK_SOURCE_SEL;
    assign cif.pin_i = SERIAL_CLOCK_PIN_I;

    csw_sck_gen #(
        .DIV_W(`CSW_DIV_W)
    ) u_sck_gen (
        .clk(CLK),
        .rst_b(RST_B),
        .cif(cif)
    );

    // -------------------------------------------------------------
    // Transfer state
    // -------------------------------------------------------------
    // Disable drops any transfer, held or running, at once
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_q <= CSW_IDLE;
        end else if (!CHANNEL_ENABLE) begin
            state_q <= CSW_IDLE;
        end else begin
            case (state_q)
                CSW_IDLE: begin
                    // A request under high select waits
                    if (start_req && ss_hi) begin
                        state_q <= CSW_PEND;
                    end else if (start_req) begin
                        state_q <= CSW_RUN;
                    end
                end
                CSW_PEND: begin
                    if (!ss_hi) begin
                        state_q <= CSW_RUN;
                    end
                end
                CSW_RUN: begin
                    // Suspension wins over a final edge
                    if (ss_hi) begin
                        state_q <= CSW_SUSP;
                    end else if (last) begin
                        state_q <= CSW_IDLE;
                    end
                end
                CSW_SUSP: begin
                    // Edges are ignored until select falls
                    if (!ss_hi) begin
                        state_q <= CSW_RUN;
                    end
                end
                default: begin
                    state_q <= CSW_IDLE;
                end
            endcase
        end
    end

    // Transmit buffer keeps its value even while stopped
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tx_q <= BITS'(`CSW_RESET_BYTE);
        end else if (TX_BUFFER_WR) begin
            tx_q <= TX_BUFFER_DATA;
        end
    end

    // Edge counter: two edges per bit
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ecnt_q <= '0;
        end else if (go || !CHANNEL_ENABLE) begin
            ecnt_q <= '0;
        end else if (run_edge && !ss_hi) begin
            ecnt_q <= ecnt_q + 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Shift register
    // -------------------------------------------------------------
    // Receive-only keeps old contents; they are shifted out unseen
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sh_q <= BITS'(`CSW_RESET_BYTE);
        end else if (!CHANNEL_ENABLE) begin
            sh_q <= BITS'(`CSW_RESET_BYTE);
        end else if (go && DUPLEX_SELECT) begin
            sh_q <= load_word;
        end else if (smp && !ss_hi) begin
            sh_q <= sh_in;
        end
    end

    // Serial out: phase 1 shows the first bit at start
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            so_q <= 1'b0;
        end else if (!CHANNEL_ENABLE) begin
            so_q <= off_val;
        end else if (!DUPLEX_SELECT) begin
            so_q <= 1'b0;
        end else if (go && DATA_PHASE) begin
            so_q <= BIT_ORDER_LSB ? load_word[0] :
                load_word[BITS-1];
        end else if (outedge && !ss_hi && !last) begin
            // Last bit holds after the final edge
            so_q <= out_bit;
        end
    end

    // -------------------------------------------------------------
    // Status
    // -------------------------------------------------------------
    // Busy covers run and suspend, not a held request
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_q <= 1'b0;
        end else if (!CHANNEL_ENABLE) begin
            busy_q <= 1'b0;
        end else if (go) begin
            busy_q <= 1'b1;
        end else if (last && !ss_hi) begin
            busy_q <= 1'b0;
        end
    end

    // Done is a one-cycle request; the owner keeps the flag
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            done_q <= 1'b0;
        end else begin
            done_q <= CHANNEL_ENABLE & last & ~ss_hi;
        end
    end

    // Pins not used by the mode are left to the port logic
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sck_oe_q <= 1'b0;
            so_oe_q <= 1'b0;
        end else begin
            sck_oe_q <= CHANNEL_ENABLE & master;
            so_oe_q <= CHANNEL_ENABLE & DUPLEX_SELECT;
        end
    end

    assign SHIFT_REG_Q = sh_q;
    assign XFER_IN_PROGRESS = busy_q;
    assign XFER_DONE_IRQ_FLAG = done_q;
    assign SERIAL_CLOCK_PIN_O = cif.sck_o;
    assign SERIAL_CLOCK_PIN_OE = sck_oe_q;
    assign SERIAL_OUT_PIN_O = so_q;
    assign SERIAL_OUT_PIN_OE = so_oe_q;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    property p_word_len;
        @(posedge CLK) disable iff (!RST_B)
        (CHANNEL_ENABLE && run_edge && !ss_hi && ecnt_q == LAST_EDGE)
            |=> done_q;
    endproperty
    a_word_len: assert property (p_word_len)
        else $error("done not raised after final edge");

    property p_duplex_go;
        @(posedge CLK) disable iff (!RST_B)
        (CHANNEL_ENABLE && DUPLEX_SELECT && TX_BUFFER_WR &&
         state_q == CSW_IDLE && !ss_hi) |=> (state_q == CSW_RUN);
    endproperty
    a_duplex_go: assert property (p_duplex_go)
        else $error("buffer write did not start transfer");

    property p_rx_go;
        @(posedge CLK) disable iff (!RST_B)
        (CHANNEL_ENABLE && !DUPLEX_SELECT && SHIFT_REG_RD &&
         state_q == CSW_IDLE && !ss_hi) |=> busy_q;
    endproperty
    a_rx_go: assert property (p_rx_go)
        else $error("shift read did not start reception");

    property p_hold;
        @(posedge CLK) disable iff (!RST_B)
        (CHANNEL_ENABLE && start_req && ss_hi && state_q == CSW_IDLE)
            |=> (state_q == CSW_PEND && !busy_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("transfer started under high select");

    property p_release;
        @(posedge CLK) disable iff (!RST_B)
        (state_q == CSW_PEND && CHANNEL_ENABLE && !ss_hi)
            |=> (state_q == CSW_RUN && busy_q);
    endproperty
    a_release: assert property (p_release)
        else $error("held request not started on select low");

    property p_suspend;
        @(posedge CLK) disable iff (!RST_B)
        (state_q == CSW_RUN && CHANNEL_ENABLE && ss_hi)
            |=> (state_q == CSW_SUSP && $stable(sh_q) && busy_q);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("transfer not suspended on select high");

    property p_busy_run;
        @(posedge CLK) disable iff (!RST_B)
        (state_q == CSW_RUN || state_q == CSW_SUSP) |-> busy_q;
    endproperty
    a_busy_run: assert property (p_busy_run)
        else $error("busy low during transfer");

    property p_done_clears;
        @(posedge CLK) disable iff (!RST_B)
        done_q |-> (!busy_q && state_q == CSW_IDLE && $past(busy_q));
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("busy still set at completion");

    property p_ports_free;
        @(posedge CLK) disable iff (!RST_B)
        (!CHANNEL_ENABLE || (!master && !DUPLEX_SELECT))
            |=> !SERIAL_CLOCK_PIN_OE;
    endproperty
    a_ports_free: assert property (p_ports_free)
        else $error("clock pin driven when stopped or slave");

    property p_disable;
        @(posedge CLK) disable iff (!RST_B)
        !CHANNEL_ENABLE |=> (!busy_q && sh_q == '0 && !so_oe_q &&
            state_q == CSW_IDLE);
    endproperty
    a_disable: assert property (p_disable)
        else $error("disable did not clear channel");
endmodule
`default_nettype wire

// ### csw_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------
// External master on the serial link
// ---------------------------------
module csw_peer (
    output logic sck,
    output logic si,
    output logic sel_b,
    input wire logic so
);
    logic [7:0] sh; // Peer shift register, MSB first
    // Clock stands high between frames, select off
    initial begin
        sck = 1'b1;
        si = 1'b0;
        sel_b = 1'b1;
        sh = 8'h00;
    end
    // Select moves well before any clock edge
    task set_sel(input logic v);
        sel_b = v;
        #60;
    endtask
    // Data out on fall, sample on rise; 125 ns period
    task bits(input int n);
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            si = sh[7];
            #62.5;
            sck = 1'b1;
            sh = {sh[6:0], so};
            #62.5;
        end
        si = ~si; // Released line must not show a stale bit
    endtask
endmodule
`default_nettype wire

// ### csw_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module csw_top_tb;
    import csw_pkg::*;
    // ---------------------------------
    // Stimulus and observation signals
    // ---------------------------------
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en, dup, gate, lsb, ckp, dap, wr, rd, loop, ext;
    csw_sel_t sel;
    logic [7:0] txd, q;
    logic busy, done, scko, sckoe, so, sooe, sck_d;
    wire logic p_sck, p_si, p_sel;
    // Master runs loop SO back, or see ones when loop is off
    wire logic si = ext ? p_si : (loop ? so : 1'b1);
    int n_mismatch, checked, n_done, n_edge, cycles;
    always #5 clk = ~clk;
    csw_top dut_u (.CLK(clk), .RST_B(rst_b), .CHANNEL_ENABLE(en),
        .DUPLEX_SELECT(dup), .SELECT_GATING_ENABLE(gate),
        .BIT_ORDER_LSB(lsb), .CLOCK_POLARITY(ckp), .DATA_PHASE(dap),
        .CLOCK_SOURCE_SEL(sel), .TX_BUFFER_WR(wr), .TX_BUFFER_DATA(txd),
        .SHIFT_REG_RD(rd), .SHIFT_REG_Q(q), .XFER_IN_PROGRESS(busy),
        .XFER_DONE_IRQ_FLAG(done), .SERIAL_CLOCK_PIN_I(p_sck),
        .SERIAL_CLOCK_PIN_O(scko), .SERIAL_CLOCK_PIN_OE(sckoe),
        .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE(sooe),
        .SERIAL_IN_PIN_I(si), .SLAVE_SELECT_IN(p_sel));
    csw_peer peer_u (.sck(p_sck), .si(p_si), .sel_b(p_sel), .so(so));
    // Count done pulses, clock edges while busy, and cut hangs
    always @(posedge clk) begin
        cycles++;
        sck_d <= scko;
        if (done === 1'b1) n_done++;
        if (busy === 1'b1 && scko !== sck_d) n_edge++;
        if (cycles == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // ---------------------------------
    // Shared tasks
    // ---------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Write strobe in duplex, read strobe in receive-only
    task go(input logic [7:0] d);
        @(posedge clk);
        txd <= d;
        wr <= dup;
        rd <= ~dup;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    // No access while busy; bounded wait, then see the pulse land
    task wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000) begin
            cyc(1);
            k++;
        end
        chk({7'h00, busy}, 8'h00, "busy stuck");
        cyc(1);
    endtask
    // ---------------------------------
    // Scenarios
    // ---------------------------------
    // All orders and timing types, loopback gives the word back
    task t_master;
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            {lsb, ckp, dap} <= m[2:0];
            cyc(2);
            n_edge = 0;
            n_done = 0;
            go(8'hA5 ^ 8'(m));
            chk({7'h00, busy}, 8'h01, "busy not set");
            wait_idle();
            chk(q, 8'hA5 ^ 8'(m), "loop data");
            chk(n_edge[7:0], 8'h10, "edge count");
            chk(8'(n_done), 8'h01, "done pulse");
            chk({7'h00, scko}, {7'h00, ~ckp}, "idle level");
            chk({6'h00, sckoe, sooe}, 8'h03, "pins");
        end
    endtask
    // Write ignored, read starts reception of ones
    task t_rx_only;
        @(posedge clk);
        {lsb, ckp, dap, loop, dup} <= 5'h00;
        @(posedge clk);
        txd <= 8'h5A;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        cyc(3);
        chk({7'h00, busy}, 8'h00, "write started rx");
        go(8'h00);
        chk({7'h00, busy}, 8'h01, "read no start");
        wait_idle();
        chk(q, 8'hFF, "rx data");
        cyc(3);
        chk({7'h00, busy}, 8'h00, "spurious start");
        chk({7'h00, sooe}, 8'h00, "unused SO driven");
    endtask
    // Disable mid-word clears busy and shifter, frees pins
    task t_disable;
        @(posedge clk);
        {dup, loop} <= 2'h3;
        go(8'hFF);
        cyc(6);
        @(posedge clk);
        en <= 1'b0;
        cyc(1);
        chk({7'h00, busy}, 8'h00, "busy kept");
        chk(q, 8'h00, "shifter kept");
        chk({6'h00, sckoe, sooe}, 8'h00, "pins driven");
        @(posedge clk);
        en <= 1'b1;
        cyc(2);
    endtask
    // Gated slave: held, started by select, suspended, resumed
    task t_slave;
        @(posedge clk);
        sel <= 3'h7;
        {lsb, ckp, dap} <= 3'h0;
        gate <= 1'b1;
        ext <= 1'b1;
        peer_u.sh = 8'h3C;
        n_done = 0;
        go(8'hC3);
        cyc(10);
        chk({7'h00, busy}, 8'h00, "start not held");
        chk({7'h00, sckoe}, 8'h00, "slave drives clock");
        peer_u.set_sel(1'b0);
        chk({7'h00, busy}, 8'h01, "pending lost");
        peer_u.bits(4);
        peer_u.set_sel(1'b1);
        cyc(20);
        chk({7'h00, busy}, 8'h01, "not suspended");
        chk(8'(n_done), 8'h00, "done early");
        peer_u.set_sel(1'b0);
        peer_u.bits(4);
        cyc(6);
        chk(8'(n_done), 8'h01, "no done");
        chk(q, 8'h3C, "slave rx");
        chk(peer_u.sh, 8'hC3, "slave tx");
    endtask
    // ---------------------------------
    // Main sequence and verdict
    // ---------------------------------
    task give_verdict;
        $display("Mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {en, dup, gate, lsb, ckp, dap, wr, rd, ext} = 9'h000;
        loop = 1'b1;
        sel = 3'h2; // Slow enough for the serial-in synchroniser
        txd = 8'h00;
        sck_d = 1'b1;
        {n_mismatch, checked, n_done, n_edge, cycles} = '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        en <= 1'b1;
        dup <= 1'b1;
        t_master();
        t_rx_only();
        t_disable();
        t_slave();
        give_verdict();
    end
endmodule
`default_nettype wire
